// File: src/smcfe_pkg.sv
package smcfe_pkg;
    localparam int SMCFE_ADDR_W = 14;
    localparam int SMCFE_ADDR_BYTES = 2;
    localparam logic [7:0] SMCFE_STATUS_RST = 8'h00;
    localparam int SMCFE_LATCH_FLAG_BIT = 1;
    localparam int SMCFE_BP0_BIT = 2;
    localparam int SMCFE_BP1_BIT = 3;
    localparam int SMCFE_WPEN_BIT = 7;
    localparam logic [7:0] SMCFE_STATUS_WMASK = 8'h8c;
    localparam int SMCFE_CLK_DIV = 12;

    typedef enum logic [7:0] {
        SMCFE_SET_LATCH_CMD = 8'h06,
        SMCFE_CLEAR_LATCH_CMD = 8'h04,
        SMCFE_STATUS_READ_CMD = 8'h05,
        SMCFE_STATUS_WRITE_CMD = 8'h01,
        SMCFE_MEMORY_READ_CMD = 8'h03,
        SMCFE_FAST_MEMORY_READ_CMD = 8'h0b,
        SMCFE_MEMORY_WRITE_CMD = 8'h02,
        SMCFE_SLEEP_CMD = 8'hb9,
        SMCFE_IDENTIFICATION_READ_CMD = 8'h9f
    } smcfe_opcode_type;

    typedef enum logic [2:0] {
        SMCFE_OPCODE = 3'b000,
        SMCFE_ADDR = 3'b001,
        SMCFE_DUMMY = 3'b010,
        SMCFE_DATA = 3'b011,
        SMCFE_IGNORE = 3'b100
    } smcfe_phase_type;
endpackage

// File: src/smcfe_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smcfe_link_if;
    logic serialClock;
    logic chipSelect_n;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    wire serialOutWire;
    // Released line shows the inverse of its last bit
    assign serialOutWire = serialOutEn ? serialOut : ~serialOut;
    modport device (
        input serialClock, chipSelect_n, serialIn,
        output serialOut, serialOutEn
    );
    modport master (
        output serialClock, chipSelect_n, serialIn,
        input serialOut, serialOutEn, serialOutWire
    );
endinterface
`default_nettype wire

// File: src/smcfe_device.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 14-bit address, top two bits dropped
// - Upper address bits from master are don't care
// - Sample on rising, drive on falling
// - Mode from clock level at select
// - Master idles clock per chosen mode
// - First byte after select is opcode
// - One opcode per select period
// - Deselected: input ignored, output off
// - Most significant bit first everywhere
// - Unknown opcode: ignore until reselect
// - Set 06h, clear 04h latch
// - Status read/write, read, fast read codes
// - Nine opcodes; two reserved codes (sleep, ID read)
// - Latch clear after reset
// - Set opcode sets the latch
// - Status flag shows latch, unwritable
// - Clear latch at deselect after writes
// - Clear command clears latch
// - Status writes finish inside the transfer; memory writes may leave the buffer after deselect
// - Eight-bit status register
// - Latch flag at status bit 1
// - Status read returns status byte
module smcfe_device
    import smcfe_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    smcfe_link_if.device link,
    input wire logic writeProtect_n,
    input wire logic [7:0] rdData,
    output logic rdReady,
    output logic wrValid,
    input wire logic wrReady,
    output logic [SMCFE_ADDR_W-1:0] wrAddr,
    output logic [7:0] wrData,
    output logic [SMCFE_ADDR_W-1:0] memAddr,
    output logic mode3,
    output logic [7:0] status,
    output logic overflow
);
    logic [1:0] sckSync_ff, csSync_ff, siSync_ff;
    logic sckPrev_ff, csPrev_ff;
    logic sck, csN, si, sckRise, sckFall, csFall, csRise;
    logic [7:0] shift_ff;
    logic [2:0] bitCnt_ff;
    logic byteDone;
    logic [7:0] rxByte;
    smcfe_phase_type phase_ff;
    logic [7:0] opcode_ff;
    logic addrIdx_ff;
    logic [SMCFE_ADDR_W-1:0] addr_ff;
    logic latch_ff;
    logic [7:0] statusCfg_ff;
    logic [7:0] txShift_ff;
    logic txActive_ff;
    logic soOut_ff, soEn_ff;
    logic mode3_ff, armed_ff;
    logic [7:0] bufData_ff [2];
    logic [SMCFE_ADDR_W-1:0] bufAddr_ff [2];
    logic [1:0] bufCnt_ff;
    logic bufWr_ff, bufRd_ff;
    logic ovf_ff;
    logic bufPush, bufPop;
    logic [7:0] statusView;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sckSync_ff <= 2'h0;
            csSync_ff <= 2'h3;
            siSync_ff <= 2'h0;
            sckPrev_ff <= 1'b0;
            csPrev_ff <= 1'b1;
        end else begin
            sckSync_ff <= {sckSync_ff[0], link.serialClock};
            csSync_ff <= {csSync_ff[0], link.chipSelect_n};
            siSync_ff <= {siSync_ff[0], link.serialIn};
            sckPrev_ff <= sckSync_ff[1];
            csPrev_ff <= csSync_ff[1];
        end
    end
    assign sck = sckSync_ff[1];
    assign csN = csSync_ff[1];
    assign si = siSync_ff[1];
    assign csFall = csPrev_ff & ~csN;
    assign csRise = ~csPrev_ff & csN;
    // Rising edge counts only once armed (mode 3 waits for a low phase)
    assign sckRise = ~csN & ~csFall & armed_ff & sck & ~sckPrev_ff;
    assign sckFall = ~csN & ~csFall & ~sck & sckPrev_ff;
    assign byteDone = sckRise && bitCnt_ff == 3'h7;
    assign rxByte = {shift_ff[6:0], si};

    // Mode detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode3_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (csFall) begin
            mode3_ff <= sck;
            armed_ff <= ~sck;
        end else if (~csN && ~sck) begin
            armed_ff <= 1'b1;
        end else if (csN) begin
            armed_ff <= 1'b0;
        end
    end

    // Bit shifter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_ff <= 8'h00;
            bitCnt_ff <= 3'h0;
        end else if (csN || csFall) begin
            bitCnt_ff <= 3'h0;
        end else if (sckRise) begin
            shift_ff <= rxByte;
            bitCnt_ff <= bitCnt_ff + 3'h1;
        end
    end

    // Command sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_ff <= SMCFE_OPCODE;
            opcode_ff <= 8'h00;
            addrIdx_ff <= 1'b0;
            addr_ff <= '0;
        end else if (csN || csFall) begin
            phase_ff <= SMCFE_OPCODE;
            addrIdx_ff <= 1'b0;
        end else if (byteDone) begin
            unique case (phase_ff)
                SMCFE_OPCODE: begin
                    opcode_ff <= rxByte;
                    unique case (rxByte)
                        SMCFE_MEMORY_READ_CMD, SMCFE_FAST_MEMORY_READ_CMD,
                        SMCFE_MEMORY_WRITE_CMD: phase_ff <= SMCFE_ADDR;
                        SMCFE_STATUS_READ_CMD, SMCFE_STATUS_WRITE_CMD:
                            phase_ff <= SMCFE_DATA;
                        SMCFE_SET_LATCH_CMD, SMCFE_CLEAR_LATCH_CMD,
                        SMCFE_SLEEP_CMD, SMCFE_IDENTIFICATION_READ_CMD:
                            phase_ff <= SMCFE_IGNORE;
                        default: phase_ff <= SMCFE_IGNORE;
                    endcase
                end
                SMCFE_ADDR: begin
                    addrIdx_ff <= 1'b1;
                    if (addrIdx_ff == 1'b0) begin
                        addr_ff[SMCFE_ADDR_W-1:8] <= rxByte[5:0];
                    end else begin
                        addr_ff[7:0] <= rxByte;
                        phase_ff <= opcode_ff == SMCFE_FAST_MEMORY_READ_CMD ?
                            SMCFE_DUMMY : SMCFE_DATA;
                    end
                end
                SMCFE_DUMMY: phase_ff <= SMCFE_DATA;
                SMCFE_DATA: begin
                    if (opcode_ff != SMCFE_STATUS_READ_CMD
                        && opcode_ff != SMCFE_STATUS_WRITE_CMD) begin
                        addr_ff <= addr_ff + 1'b1;
                    end
                end
                SMCFE_IGNORE: phase_ff <= SMCFE_IGNORE;
                default: phase_ff <= SMCFE_IGNORE;
            endcase
        end
    end

    // Write enable latch and status configuration
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_ff <= 1'b0;
            statusCfg_ff <= SMCFE_STATUS_RST;
        end else begin
            if (byteDone && phase_ff == SMCFE_OPCODE
                && rxByte == SMCFE_SET_LATCH_CMD) begin
                latch_ff <= 1'b1;
            end else if (csRise && phase_ff != SMCFE_OPCODE
                && (opcode_ff == SMCFE_CLEAR_LATCH_CMD
                || opcode_ff == SMCFE_STATUS_WRITE_CMD
                || opcode_ff == SMCFE_MEMORY_WRITE_CMD)) begin
                latch_ff <= 1'b0;
            end
            if (byteDone && phase_ff == SMCFE_DATA
                && opcode_ff == SMCFE_STATUS_WRITE_CMD && latch_ff
                && !(statusCfg_ff[SMCFE_WPEN_BIT] && !writeProtect_n)) begin
                statusCfg_ff <= rxByte & SMCFE_STATUS_WMASK;
            end
        end
    end
    always_comb begin
        statusView = statusCfg_ff;
        statusView[SMCFE_LATCH_FLAG_BIT] = latch_ff;
    end

    // Two-entry write buffer
    assign bufPush = byteDone && phase_ff == SMCFE_DATA && latch_ff
        && opcode_ff == SMCFE_MEMORY_WRITE_CMD && bufCnt_ff != 2'h2;
    assign bufPop = wrValid && wrReady;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bufCnt_ff <= 2'h0;
            bufWr_ff <= 1'b0;
            bufRd_ff <= 1'b0;
            ovf_ff <= 1'b0;
            bufData_ff[0] <= 8'h00;
            bufData_ff[1] <= 8'h00;
            bufAddr_ff[0] <= '0;
            bufAddr_ff[1] <= '0;
        end else begin
            if (bufPush) begin
                bufData_ff[bufWr_ff] <= rxByte;
                bufAddr_ff[bufWr_ff] <= addr_ff;
                bufWr_ff <= ~bufWr_ff;
            end
            if (bufPop) begin
                bufRd_ff <= ~bufRd_ff;
            end
            bufCnt_ff <= bufCnt_ff + {1'b0, bufPush} - {1'b0, bufPop};
            if (byteDone && phase_ff == SMCFE_DATA && latch_ff
                && opcode_ff == SMCFE_MEMORY_WRITE_CMD
                && bufCnt_ff == 2'h2) begin
                ovf_ff <= 1'b1;
            end
        end
    end

    // Serial output, changed on falling edges only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txShift_ff <= 8'h00;
            txActive_ff <= 1'b0;
            soOut_ff <= 1'b0;
            soEn_ff <= 1'b0;
        end else if (csN) begin
            txActive_ff <= 1'b0;
            soEn_ff <= 1'b0;
        end else begin
            if (byteDone && ((phase_ff == SMCFE_OPCODE
                && rxByte == SMCFE_STATUS_READ_CMD)
                || (phase_ff == SMCFE_DATA
                && opcode_ff == SMCFE_STATUS_READ_CMD))) begin
                txShift_ff <= statusView;
                txActive_ff <= 1'b1;
            end else if (byteDone && (opcode_ff == SMCFE_MEMORY_READ_CMD
                || opcode_ff == SMCFE_FAST_MEMORY_READ_CMD)
                && ((phase_ff == SMCFE_ADDR && addrIdx_ff
                && opcode_ff == SMCFE_MEMORY_READ_CMD)
                || phase_ff == SMCFE_DUMMY || phase_ff == SMCFE_DATA)) begin
                txShift_ff <= rdData;
                txActive_ff <= 1'b1;
            end else if (sckFall && txActive_ff) begin
                soOut_ff <= txShift_ff[7];
                soEn_ff <= 1'b1;
                txShift_ff <= {txShift_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdReady <= 1'b0;
            wrValid <= 1'b0;
            wrAddr <= '0;
            wrData <= 8'h00;
            memAddr <= '0;
            mode3 <= 1'b0;
            status <= SMCFE_STATUS_RST;
            overflow <= 1'b0;
        end else begin
            rdReady <= ~csN && (phase_ff == SMCFE_DATA
                || phase_ff == SMCFE_DUMMY);
            if (bufPop) begin
                wrValid <= 1'b0;
            end else if (bufCnt_ff != 2'h0 && !wrValid) begin
                wrValid <= 1'b1;
                wrAddr <= bufAddr_ff[bufRd_ff];
                wrData <= bufData_ff[bufRd_ff];
            end
            memAddr <= addr_ff;
            mode3 <= mode3_ff;
            status <= statusView;
            overflow <= ovf_ff;
        end
    end
    assign link.serialOut = soOut_ff;
    assign link.serialOutEn = soEn_ff;
endmodule // smcfe_device
`default_nettype wire

// File: src/smcfe_master.sv
`timescale 1ns/1ps
`default_nettype none
module smcfe_master
    import smcfe_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    smcfe_link_if.master link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic useMode3,
    input wire logic [3:0] cmdBytes,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    output logic rxValid,
    output logic [7:0] rxData,
    input wire logic rxReady,
    output logic busy
);
    logic [1:0] soSync_ff;
    logic [7:0] div_ff;
    logic [7:0] shOut_ff, shIn_ff;
    logic [2:0] bit_ff;
    logic [3:0] left_ff;
    logic sck_ff, cs_ff, si_ff, run_ff, idle_ff, lead_ff, tail_ff, tick, stall;
    logic [7:0] bufD_ff [2];
    logic [1:0] bufN_ff;
    logic bufW_ff, bufR_ff, push;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            soSync_ff <= 2'h0;
        end else begin
            soSync_ff <= {soSync_ff[0], link.serialOutWire};
        end
    end
    assign tick = div_ff == 8'(SMCFE_CLK_DIV/2 - 1);
    // No rising edge while the receive buffer is full
    assign stall = bufN_ff == 2'h2 && !sck_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= (tick || !run_ff) ? 8'h00 : div_ff + 8'h01;
        end
    end
    assign push = run_ff && tick && !sck_ff && !tail_ff && bit_ff == 3'h7
        && !stall;
    // Clock, select and MSB-first shifting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_ff <= 1'b0;
            idle_ff <= 1'b0;
            lead_ff <= 1'b0;
            tail_ff <= 1'b0;
            cs_ff <= 1'b1;
            si_ff <= 1'b0;
            run_ff <= 1'b0;
            shOut_ff <= 8'h00;
            shIn_ff <= 8'h00;
            bit_ff <= 3'h0;
            left_ff <= 4'h0;
            cmdReady <= 1'b0;
            txReady <= 1'b0;
            busy <= 1'b0;
        end else begin
            cmdReady <= 1'b0;
            txReady <= 1'b0;
            if (!run_ff) begin
                cs_ff <= 1'b1;
                sck_ff <= useMode3;
                idle_ff <= useMode3;
                busy <= 1'b0;
                if (cmdValid && txValid && cmdBytes != 4'h0 && cs_ff) begin
                    run_ff <= 1'b1;
                    cs_ff <= 1'b0;
                    cmdReady <= 1'b1;
                    txReady <= 1'b1;
                    shOut_ff <= {txData[6:0], 1'b0};
                    si_ff <= txData[7];
                    bit_ff <= 3'h0;
                    left_ff <= cmdBytes;
                    lead_ff <= useMode3;
                    tail_ff <= 1'b0;
                    busy <= 1'b1;
                end
            end else if (tick && !stall) begin
                if (!sck_ff && tail_ff) begin
                    run_ff <= 1'b0;
                    cs_ff <= 1'b1;
                end else if (!sck_ff) begin
                    sck_ff <= 1'b1;
                    shIn_ff <= {shIn_ff[6:0], soSync_ff[1]};
                end else if (lead_ff) begin
                    // Mode 3 lead fall, first bit already on the line
                    sck_ff <= 1'b0;
                    lead_ff <= 1'b0;
                end else if (bit_ff != 3'h7) begin
                    sck_ff <= ~sck_ff;
                    si_ff <= shOut_ff[7];
                    shOut_ff <= {shOut_ff[6:0], 1'b0};
                    bit_ff <= bit_ff + 3'h1;
                end else if (left_ff != 4'h1 && txValid) begin
                    sck_ff <= ~sck_ff;
                    si_ff <= txData[7];
                    shOut_ff <= {txData[6:0], 1'b0};
                    txReady <= 1'b1;
                    bit_ff <= 3'h0;
                    left_ff <= left_ff - 4'h1;
                end else if (left_ff == 4'h1 && idle_ff) begin
                    run_ff <= 1'b0;
                    cs_ff <= 1'b1;
                end else if (left_ff == 4'h1) begin
                    // Mode 0 brings the clock low before deselect
                    sck_ff <= 1'b0;
                    tail_ff <= 1'b1;
                end
            end
        end
    end
    // Receive buffer of two bytes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bufN_ff <= 2'h0;
            bufW_ff <= 1'b0;
            bufR_ff <= 1'b0;
            bufD_ff[0] <= 8'h00;
            bufD_ff[1] <= 8'h00;
            rxValid <= 1'b0;
            rxData <= 8'h00;
        end else begin
            if (push) begin
                bufD_ff[bufW_ff] <= {shIn_ff[6:0], soSync_ff[1]};
                bufW_ff <= ~bufW_ff;
            end
            if (rxValid && rxReady) begin
                rxValid <= 1'b0;
            end else if (!rxValid && bufN_ff != 2'h0) begin
                rxValid <= 1'b1;
                rxData <= bufD_ff[bufR_ff];
                bufR_ff <= ~bufR_ff;
            end
            bufN_ff <= bufN_ff + {1'b0, push}
                - {1'b0, !rxValid && bufN_ff != 2'h0};
        end
    end
    assign link.serialClock = sck_ff;
    assign link.chipSelect_n = cs_ff;
    assign link.serialIn = si_ff;
endmodule // smcfe_master
`default_nettype wire

// File: dv/smcfe_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smcfe_link_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic serialClock,
    input wire logic chipSelect_n,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic serialOutWire
);
    logic sclk_ff;
    logic [4:0] riseCnt_ff;
    logic [7:0] op_ff;
    logic isRead;
    logic isKnown;
    logic rise;
    assign rise = serialClock && !sclk_ff;
    assign isRead = op_ff inside {8'h05, 8'h03, 8'h0b, 8'h9f};
    assign isKnown = isRead || (op_ff inside {8'h06, 8'h04, 8'h01, 8'h02,
        8'hb9});
    always_ff @(posedge clk or posedge reset) begin
        if (reset) sclk_ff <= 1'b0;
        else sclk_ff <= serialClock;
    end
    // Rising link edges since select, saturating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) riseCnt_ff <= 5'h00;
        else if (chipSelect_n) riseCnt_ff <= 5'h00;
        else if (rise && riseCnt_ff != 5'h1f) riseCnt_ff <= riseCnt_ff + 5'h01;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) op_ff <= 8'h00;
        else if (!chipSelect_n && rise && riseCnt_ff < 5'h08)
            op_ff <= {op_ff[6:0], serialIn};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_off_desel;
        chipSelect_n [*4] |-> !serialOutEn;
    endproperty
    property p_out_on_low;
        serialOutEn && $changed(serialOut) |-> !serialClock;
    endproperty
    property p_hold_high;
        $rose(serialClock) && serialOutEn |=> $stable(serialOut) [*3];
    endproperty
    property p_read_only;
        serialOutEn && !chipSelect_n |-> riseCnt_ff >= 5'h08 && isRead;
    endproperty
    property p_invalid;
        !chipSelect_n && riseCnt_ff >= 5'h08 && !isKnown |->
            !serialOutEn ##1 !serialOutEn;
    endproperty
    property p_status_drive;
        !chipSelect_n && op_ff == 8'h05 && riseCnt_ff >= 5'h09 &&
            riseCnt_ff <= 5'h0f |-> serialOutEn && serialOutWire == serialOut;
    endproperty
    property p_idle_clk;
        $rose(chipSelect_n) |=> $stable(serialClock) [*3];
    endproperty
    property p_select_still;
        $fell(chipSelect_n) |-> $stable(serialClock) ##1 $stable(serialClock);
    endproperty
    a_off_desel: assert property (p_off_desel)
        else $error("serial output driven while deselected");
    a_out_on_low: assert property (p_out_on_low)
        else $error("serial output changed with link clock high");
    a_hold_high: assert property (p_hold_high)
        else $error("serial output moved after rising link edge");
    a_read_only: assert property (p_read_only)
        else $error("serial output driven outside a read reply");
    a_invalid: assert property (p_invalid)
        else $error("serial output driven after unknown opcode");
    a_status_drive: assert property (p_status_drive)
        else $error("status reply not driven");
    a_idle_clk: assert property (p_idle_clk)
        else $error("link clock moved after deselect");
    a_select_still: assert property (p_select_still)
        else $error("link clock moved at select");
    c_status: cover property (op_ff == 8'h05 && riseCnt_ff == 5'h10);
    c_mode3: cover property ($fell(chipSelect_n) && serialClock);
    c_bad: cover property (riseCnt_ff == 5'h08 && !isKnown);
endmodule // smcfe_link_checker
`default_nettype wire

// File: dv/spi_memory_command_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_memory_command_front_end_tb;
    import smcfe_pkg::*;
    logic clk, reset, cmdValid, cmdReady, useMode3, txValid, txReady;
    logic rxValid, busy, wrValid, mode3, wpN;
    logic rxReady = 1'b0;
    logic wrReady = 1'b0;
    logic [3:0] cmdBytes;
    logic [7:0] txData, rxData, rdData, wrData, status;
    logic [SMCFE_ADDR_W-1:0] wrAddr, memAddr;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] rnd = 32'h00013257;
    bit expChk[$];
    logic [7:0] expVal[$];
    logic [13:0] wrExpA[$];
    logic [7:0] wrExpD[$];
    logic [7:0] st;
    logic latchExp;
    logic ovf, rdRdy;
    smcfe_link_if link();
    smcfe_device i_smcfe_device (.clk(clk), .reset(reset), .link(link),
        .writeProtect_n(wpN), .rdData(rdData), .rdReady(rdRdy),
        .wrValid(wrValid),
        .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData),
        .memAddr(memAddr), .mode3(mode3), .status(status), .overflow(ovf));
    smcfe_master i_smcfe_master (.clk(clk), .reset(reset), .link(link),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .useMode3(useMode3),
        .cmdBytes(cmdBytes), .txValid(txValid), .txData(txData),
        .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .busy(busy));
    smcfe_link_checker i_smcfe_link_checker (.clk(clk), .reset(reset),
        .serialClock(link.serialClock), .chipSelect_n(link.chipSelect_n),
        .serialIn(link.serialIn), .serialOut(link.serialOut),
        .serialOutEn(link.serialOutEn), .serialOutWire(link.serialOutWire));
    assign rdData = memAddr[7:0] ^ 8'h5a;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Random stalls on both receive paths
    always @(posedge clk) begin
        rnd <= lfsr_next(rnd);
        rxReady <= rnd[2] | rnd[7];
        wrReady <= rnd[4] | rnd[9];
    end
    task automatic cmp8(input string what, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp14(input string what, input logic [13:0] e,
        input logic [13:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    always @(posedge clk) begin
        if (rxValid === 1'b1 && rxReady) begin
            if (expChk.size() == 0) cmp8("rx count", 8'h00, 8'h01);
            else if (expChk.pop_front())
                cmp8("status byte", expVal.pop_front(), rxData);
            else void'(expVal.pop_front());
        end
        if (wrValid === 1'b1 && wrReady) begin
            if (wrExpA.size() == 0) cmp8("write count", 8'h00, 8'h01);
            else begin
                cmp14("write address", wrExpA.pop_front(), wrAddr);
                cmp8("write data", wrExpD.pop_front(), wrData);
            end
        end
    end
    task automatic frame(input logic [7:0] b[$], input bit chk,
        input logic [7:0] ex);
        int i;
        int k;
        i = 0;
        k = 0;
        foreach (b[j]) begin
            expChk.push_back(chk && j == b.size() - 1);
            expVal.push_back(ex);
        end
        @(posedge clk);
        cmdBytes <= 4'(b.size());
        cmdValid <= 1'b1;
        txValid <= 1'b1;
        txData <= b[0];
        while (i < b.size() && k < 4000) begin
            @(posedge clk);
            k++;
            if (cmdReady) cmdValid <= 1'b0;
            if (txReady) begin
                i++;
                if (i < b.size()) txData <= b[i];
                else txValid <= 1'b0;
            end
        end
        @(posedge clk);
        while (busy !== 1'b0 && k < 8000) begin
            @(posedge clk);
            k++;
        end
        if (busy !== 1'b0) begin
            n_errors++;
            $display("ERROR frame expected idle seen busy");
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic rd();
        frame('{8'h05, 8'h00}, 1'b1, st | {6'h00, latchExp, 1'b0});
        cmp8("status port", st | {6'h00, latchExp, 1'b0}, status);
    endtask
    task automatic run_mode(input logic m);
        logic [7:0] d;
        logic [7:0] bad[5];
        bad = '{8'hc3, 8'hc2, 8'h5a, 8'h5b, 8'hff};
        @(posedge clk);
        reset <= 1'b1;
        useMode3 <= m;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        st = 8'h00;
        latchExp = 1'b0;
        rd();
        cmp8("mode", {7'h00, m}, {7'h00, mode3});
        frame('{8'h06}, 1'b0, 8'h00);
        latchExp = 1'b1;
        rd();
        d = rnd[7:0];
        wrExpA.push_back(14'h0123);
        wrExpD.push_back(d);
        wrExpA.push_back(14'h0124);
        wrExpD.push_back(~d);
        frame('{8'h02, 8'hc1, 8'h23, d, ~d}, 1'b0, 8'h00);
        latchExp = 1'b0;
        rd();
        frame('{8'h02, 8'h00, 8'h10, 8'h77}, 1'b0, 8'h00);
        frame('{8'h06}, 1'b0, 8'h00);
        frame('{8'h04}, 1'b0, 8'h00);
        rd();
        foreach (bad[i]) begin
            frame('{bad[i], 8'h06, 8'h05, 8'h00}, 1'b0, 8'h00);
            rd();
        end
        frame('{8'h06}, 1'b0, 8'h00);
        frame('{8'h01, 8'hff}, 1'b0, 8'h00);
        st = 8'h8c;
        rd();
        frame('{8'h06}, 1'b0, 8'h00);
        frame('{8'h01, 8'h00}, 1'b0, 8'h00);
        st = 8'h00;
        rd();
        frame('{8'h06}, 1'b0, 8'h00);
        cmp8("overflow", 8'h00, {7'h00, ovf});
        cmp8("read ready", 8'h00, {7'h00, rdRdy});
        $display("mode %0d tests done", m);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        cmdValid = 1'b0;
        txValid = 1'b0;
        txData = 8'h00;
        cmdBytes = 4'h0;
        useMode3 = 1'b0;
        wpN = 1'b1;
        run_mode(1'b0);
        run_mode(1'b1);
        repeat (2000) @(posedge clk);
        cmp8("pending", 8'h00, 8'(expChk.size() + wrExpA.size()));
        finish_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end
endmodule // spi_memory_command_front_end_tb
`default_nettype wire
